// ===== common/qsmc_pkg.sv
// Package: constants and types of the quad serdes mode control block.
// Assumes one 100 MHz bus clock that also stands for the reference clock.
package qsmc_pkg;

  // Register byte offsets
  localparam logic [11:0] QSMC_OFF_CTRL  = 12'h000;
  localparam logic [11:0] QSMC_OFF_MODE  = 12'h004;
  localparam logic [11:0] QSMC_OFF_STAT  = 12'h008;
  localparam logic [11:0] QSMC_OFF_ISTAT = 12'h00c;
  localparam logic [11:0] QSMC_OFF_IMASK = 12'h010;

  // Control field positions and reset values
  localparam int          QSMC_CTRL_PER_LSB = 0;
  localparam logic [7:0]  QSMC_PER_RST      = 8'h10;
  localparam logic [31:0] QSMC_IMASK_RST    = 32'h0000_0000;

  // Word clock ratios to the serial baud
  localparam logic [4:0] QSMC_RATIO_SINGLE = 5'h0a;
  localparam logic [4:0] QSMC_RATIO_DUAL   = 5'h14;

  // Self-test pattern: 256 words, 8 bits wide
  localparam int QSMC_PAT_W = 8;
  localparam int QSMC_WORD_W = 10;

  // Static mode pins
  typedef struct packed {
    logic reserved_in;
    logic buffer_recenter_n;
    logic self_test_enable;
    logic freq_locked_mode;
    logic codec_enable;
    logic full_rate;
    logic ratio_sel;
  } qsmc_mode_s;

  // Boundary-scan controller states
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE  = 4'h1, TAP_SDR  = 4'h2,
    TAP_CDR   = 4'h3, TAP_SHDR  = 4'h4, TAP_E1DR = 4'h5,
    TAP_PDR   = 4'h6, TAP_E2DR  = 4'h7, TAP_UDR  = 4'h8,
    TAP_SIR   = 4'h9, TAP_CIR   = 4'ha, TAP_SHIR = 4'hb,
    TAP_E1IR  = 4'hc, TAP_PIR   = 4'hd, TAP_E2IR = 4'he,
    TAP_UIR   = 4'hf
  } qsmc_tap_e;

  localparam logic [1:0] QSMC_IR_CAPTURE = 2'h1;

  // Next pattern byte
  function automatic logic [7:0] qsmc_inc(input logic [7:0] v);
    return v + 8'h01;
  endfunction : qsmc_inc

endpackage : qsmc_pkg

// ===== verilog/qsmc_pattern_check.sv
// One receive channel's checker for the incrementing self-test pattern.
// Assumes rx data and valid are synchronous to hclk.
`timescale 1ns/1ps
module qsmc_pattern_check (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       valid,
  input  wire logic [7:0] rx_byte,
  output logic            err_n,
  output logic            err_event
);
  import qsmc_pkg::*;

  typedef struct packed {
    logic       have;
    logic [7:0] prev;
    logic       err_n;
    logic       ev;
  } qsmc_chk_s;

  qsmc_chk_s q, d;

  always_comb begin
    d    = q;
    d.ev = 1'b0;
    if (!enable) begin
      d.have  = 1'b0;
      d.err_n = 1'b1;
    end else if (valid) begin
      d.prev = rx_byte;
      d.have = 1'b1;
      if (q.have) begin
        d.err_n = (rx_byte != qsmc_inc(q.prev));
        d.ev    = (rx_byte != qsmc_inc(q.prev));
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{have: 1'b0, prev: 8'h00, err_n: 1'b1, ev: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign err_n     = q.err_n;
  assign err_event = q.ev;

endmodule : qsmc_pattern_check

// ===== verilog/qsmc_word_sync.sv
// Word-sync generator and IDLE rate-matching steering.
// Assumes word_sync_in is synchronous to hclk.
`timescale 1ns/1ps
module qsmc_word_sync (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       recenter,
  input  wire logic [7:0] period,
  input  wire logic       freq_locked,
  input  wire logic       ws_in,
  output logic            ws_out,
  output logic            idle_insert,
  output logic            idle_delete
);
  import qsmc_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic       ws_in_q;
    logic       ws;
    logic       ins;
    logic       del;
  } qsmc_ws_s;

  qsmc_ws_s q, d;
  logic     ws_rise;

  always_comb begin
    d       = q;
    ws_rise = ws_in & ~q.ws_in_q;
    d.ws_in_q = ws_in;
    d.ins   = 1'b0;
    d.del   = 1'b0;
    d.ws    = 1'b0;
    if (recenter) begin
      d.cnt = 8'h00;
    end else if (ws_rise) begin
      d.cnt = 8'h00;
      if (!freq_locked) begin
        d.del = (q.cnt < {1'b0, period[7:1]});
        d.ins = (q.cnt >= {1'b0, period[7:1]});
      end
    end else if (q.cnt >= period) begin
      d.cnt = 8'h00;
    end else begin
      d.cnt = q.cnt + 8'h01;
    end
    if (!recenter && q.cnt == 8'h00) begin
      d.ws = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ws_out      = q.ws;
  assign idle_insert = q.ins;
  assign idle_delete = q.del;

endmodule : qsmc_word_sync

// ===== verilog/qsmc_top.sv
// Top of the quad serdes mode control block with an AHB-Lite slave.
// Assumes hclk is the reference clock and all pins are synchronous to it.
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps

module qsmc_top #(
  parameter int NCH = 4
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  output logic                        irq,
  input  wire qsmc_pkg::qsmc_mode_s   mode_pins,
  input  wire logic [NCH*10-1:0]      tx_data,
  input  wire logic [NCH-1:0]         tx_ctrl,
  output logic [NCH*10-1:0]           tx_word,
  output logic [NCH-1:0]              tx_is_ctrl,
  input  wire logic [NCH*10-1:0]      rx_data,
  input  wire logic [NCH-1:0]         rx_valid,
  output logic [NCH-1:0]              pattern_error_flag_n,
  input  wire logic                   word_sync_in,
  output logic                        word_sync_out,
  output logic                        idle_insert,
  output logic                        idle_delete,
  output logic                        recenter,
  output logic [4:0]                  word_clk_ratio,
  output logic                        half_rate,
  output logic                        coding_bypass,
  input  wire logic                   tck,
  input  wire logic                   tms,
  input  wire logic                   tdi,
  input  wire logic                   trst_n,
  output logic                        tdo
);
  import qsmc_pkg::*;

  localparam int INT_W = NCH + 2;

  if (NCH < 1 || NCH > 8) begin : g_bad_nch
    $error("NCH must lie between 1 and 8");
  end

  typedef struct packed {
    logic [NCH-1:0][9:0] tx_word;
    logic [NCH-1:0]      tx_k;
    logic [7:0]          pat;
    logic                ph;
    logic                ap_act;
    logic                ap_wr;
    logic [11:0]         ap_off;
    logic [31:0]         rdata;
    logic [7:0]          period;
    logic [INT_W-1:0]    ist;
    logic [INT_W-1:0]    imask;
    logic                recenter;
    logic [4:0]          ratio;
    logic                half;
    logic                bypass;
    logic                tck_q;
    qsmc_tap_e           tap;
    logic [1:0]          ir;
    logic                byp;
    logic                tdo;
    logic                ws_in_q;
  } qsmc_st_s;

  qsmc_st_s          q, d;
  logic [NCH-1:0]    chk_err_n;
  logic [NCH-1:0]    chk_ev;
  logic              ws_out_w;
  logic              ins_w;
  logic              del_w;
  logic [INT_W-1:0]  ev;
  logic [INT_W-1:0]  clr;
  logic              ap_take;
  logic              tck_rise;
  logic              pat_step;
  logic [9:0]        w;
  logic [31:0]       rd;

  // Receive pattern checkers
  for (genvar c = 0; c < NCH; c++) begin : g_chk
    qsmc_pattern_check u_chk (
      .clk       (hclk),
      .rst_n     (hresetn),
      .enable    (mode_pins.self_test_enable),
      .valid     (rx_valid[c]),
      .rx_byte   (rx_data[c*10 +: 8]),
      .err_n     (chk_err_n[c]),
      .err_event (chk_ev[c])
    );
  end

  // Word alignment and rate matching
  qsmc_word_sync u_ws (
    .clk         (hclk),
    .rst_n       (hresetn),
    .recenter    (q.recenter),
    .period      (q.period),
    .freq_locked (mode_pins.freq_locked_mode),
    .ws_in       (word_sync_in),
    .ws_out      (ws_out_w),
    .idle_insert (ins_w),
    .idle_delete (del_w)
  );

  // Next state of the boundary-scan controller
  function automatic qsmc_tap_e tap_next(input qsmc_tap_e s,
                                         input logic m);
    case (s)
      TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:  tap_next = m ? TAP_SDR   : TAP_IDLE;
      TAP_SDR:   tap_next = m ? TAP_SIR   : TAP_CDR;
      TAP_CDR:   tap_next = m ? TAP_E1DR  : TAP_SHDR;
      TAP_SHDR:  tap_next = m ? TAP_E1DR  : TAP_SHDR;
      TAP_E1DR:  tap_next = m ? TAP_UDR   : TAP_PDR;
      TAP_PDR:   tap_next = m ? TAP_E2DR  : TAP_PDR;
      TAP_E2DR:  tap_next = m ? TAP_UDR   : TAP_SHDR;
      TAP_UDR:   tap_next = m ? TAP_SDR   : TAP_IDLE;
      TAP_SIR:   tap_next = m ? TAP_RESET : TAP_CIR;
      TAP_CIR:   tap_next = m ? TAP_E1IR  : TAP_SHIR;
      TAP_SHIR:  tap_next = m ? TAP_E1IR  : TAP_SHIR;
      TAP_E1IR:  tap_next = m ? TAP_UIR   : TAP_PIR;
      TAP_PIR:   tap_next = m ? TAP_E2IR  : TAP_PIR;
      TAP_E2IR:  tap_next = m ? TAP_UIR   : TAP_SHIR;
      TAP_UIR:   tap_next = m ? TAP_SDR   : TAP_IDLE;
      default:   tap_next = TAP_RESET;
    endcase
  endfunction : tap_next

  always_comb begin
    d        = q;
    w        = 10'h000;
    rd       = 32'h0000_0000;
    clr      = '0;

    // Static mode decode
    d.ratio  = mode_pins.ratio_sel ? QSMC_RATIO_DUAL
                                   : QSMC_RATIO_SINGLE;
    d.half   = ~mode_pins.full_rate;
    d.bypass = ~mode_pins.codec_enable;
    d.recenter = ~mode_pins.buffer_recenter_n;

    // Self-test counter, one step per word at the selected rate
    d.ph     = mode_pins.full_rate ? 1'b0 : ~q.ph;
    pat_step = mode_pins.full_rate | q.ph;
    if (!mode_pins.self_test_enable) begin
      d.pat = 8'h00;
    end else if (pat_step) begin
      d.pat = qsmc_inc(q.pat);
    end

    // Transmit input register
    for (int c = 0; c < NCH; c++) begin
      w = tx_data[c*10 +: 10];
      if (mode_pins.self_test_enable) begin
        d.tx_word[c] = {2'b00, q.pat};
        d.tx_k[c]    = 1'b0;
      end else if (mode_pins.codec_enable) begin
        d.tx_word[c] = {2'b00, w[7:0]};
        d.tx_k[c]    = tx_ctrl[c];
      end else begin
        d.tx_word[c] = w;
        d.tx_k[c]    = 1'b0;
      end
    end

    // Events for the interrupt status
    d.ws_in_q = word_sync_in;
    ev = {q.recenter & mode_pins.buffer_recenter_n,
          word_sync_in & ~q.ws_in_q,
          chk_ev};

    // Bus data phase: write
    if (q.ap_act && q.ap_wr) begin
      if (q.ap_off == QSMC_OFF_CTRL) begin
        d.period = hwdata[QSMC_CTRL_PER_LSB +: 8];
      end else if (q.ap_off == QSMC_OFF_IMASK) begin
        d.imask = hwdata[INT_W-1:0];
      end
    end

    // Bus address phase
    ap_take  = hsel & htrans[1] & hready;
    d.ap_act = ap_take;
    d.ap_wr  = hwrite;
    d.ap_off = haddr[11:0];
    if (ap_take && !hwrite) begin
      if (haddr[11:0] == QSMC_OFF_CTRL) begin
        rd[QSMC_CTRL_PER_LSB +: 8] = d.period;
      end else if (haddr[11:0] == QSMC_OFF_MODE) begin
        rd[6:0] = mode_pins;
      end else if (haddr[11:0] == QSMC_OFF_STAT) begin
        rd[NCH-1:0] = ~chk_err_n;
        rd[8]       = ws_out_w;
        rd[9]       = q.recenter;
      end else if (haddr[11:0] == QSMC_OFF_ISTAT) begin
        rd[INT_W-1:0] = q.ist;
        clr           = '1;
      end else if (haddr[11:0] == QSMC_OFF_IMASK) begin
        rd[INT_W-1:0] = d.imask;
      end
      d.rdata = rd;
    end

    // Sticky status: a new event beats a read clear
    d.ist = (q.ist & ~clr) | ev;

    // Boundary-scan port, clocked on sampled test clock edges
    d.tck_q  = tck;
    tck_rise = tck & ~q.tck_q;
    if (!trst_n) begin
      d.tap = TAP_RESET;
      d.ir  = QSMC_IR_CAPTURE;
    end else if (tck_rise) begin
      d.tap = tap_next(q.tap, tms);
      case (q.tap)
        TAP_CDR: begin
          d.byp = 1'b0;
        end
        TAP_SHDR: begin
          d.tdo = q.byp;
          d.byp = tdi;
        end
        TAP_CIR: begin
          d.ir = QSMC_IR_CAPTURE;
        end
        TAP_SHIR: begin
          d.tdo = q.ir[0];
          d.ir  = {tdi, q.ir[1]};
        end
        default: begin
          d.tdo = q.tdo;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q          <= '0;
      q.period   <= QSMC_PER_RST;
      q.imask    <= QSMC_IMASK_RST[INT_W-1:0];
      q.ratio    <= QSMC_RATIO_SINGLE;
      q.tap      <= TAP_RESET;
      q.ir       <= QSMC_IR_CAPTURE;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign hrdata               = q.rdata;
  assign irq                  = |(q.ist & q.imask);
  assign tx_word              = q.tx_word;
  assign tx_is_ctrl           = q.tx_k;
  assign pattern_error_flag_n = chk_err_n;
  assign word_sync_out        = ws_out_w;
  assign idle_insert          = ins_w;
  assign idle_delete          = del_w;
  assign recenter             = q.recenter;
  assign word_clk_ratio       = q.ratio;
  assign half_rate            = q.half;
  assign coding_bypass        = q.bypass;
  assign tdo                  = q.tdo;

endmodule : qsmc_top

// ===== tb/qsmc_props.sv
// Checker: port relations of the mode control top.
// Assumes binding into qsmc_top; one clock, async active-low reset.
`timescale 1ns/1ps
module qsmc_props #(
  parameter int NCH = 4
) (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire qsmc_pkg::qsmc_mode_s mode_pins,
  input wire logic [NCH*10-1:0]    tx_data,
  input wire logic [NCH-1:0]       tx_ctrl,
  input wire logic [NCH*10-1:0]    tx_word,
  input wire logic [NCH-1:0]       tx_is_ctrl,
  input wire logic [NCH-1:0]       pattern_error_flag_n,
  input wire logic                 word_sync_out,
  input wire logic                 idle_insert,
  input wire logic                 idle_delete,
  input wire logic                 recenter,
  input wire logic [4:0]           word_clk_ratio,
  input wire logic                 half_rate,
  input wire logic                 coding_bypass
);
  import qsmc_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence st_full;
    mode_pins.self_test_enable && mode_pins.full_rate;
  endsequence
  sequence raw_path;
    !mode_pins.codec_enable && !mode_pins.self_test_enable;
  endsequence
  sequence locked_3;
    mode_pins.freq_locked_mode [*3];
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_ratio_sel: assert property (1'b1 |=> word_clk_ratio ==
    ($past(mode_pins.ratio_sel) ? QSMC_RATIO_DUAL : QSMC_RATIO_SINGLE))
    else $error("word clock ratio wrong");
  chk_rate_sel: assert property (
    1'b1 |=> half_rate == !$past(mode_pins.full_rate))
    else $error("half rate wrong");
  chk_codec_sel: assert property (
    1'b1 |=> coding_bypass == !$past(mode_pins.codec_enable))
    else $error("coding bypass wrong");
  chk_buf_recenter: assert property (
    !mode_pins.buffer_recenter_n |=> recenter)
    else $error("no recenter while reset pin low");
  chk_raw_word: assert property (raw_path |=>
    tx_word == $past(tx_data) && tx_is_ctrl == '0)
    else $error("raw word not passed");
  chk_coded_word: assert property (
    mode_pins.codec_enable && !mode_pins.self_test_enable |=>
    tx_word[9:0] == {2'b00, $past(tx_data[7:0])} &&
    tx_is_ctrl == $past(tx_ctrl))
    else $error("coded word not passed");
  chk_pattern_step: assert property (st_full [*3] |=>
    tx_word[7:0] == $past(tx_word[7:0]) + 8'h01 && tx_word[9:8] == 2'b00)
    else $error("test pattern did not step");
  chk_flag_idle: assert property (
    !mode_pins.self_test_enable |=> &pattern_error_flag_n)
    else $error("error flag low with test off");
  chk_sync_pulse: assert property (
    word_sync_out |=> !word_sync_out)
    else $error("word sync pulse too long");
  chk_locked_idle: assert property (
    locked_3 |-> !idle_insert && !idle_delete)
    else $error("rate matching while locked");
endmodule : qsmc_props

bind qsmc_top qsmc_props #(.NCH(NCH)) i_qsmc_props (
  .hclk, .hresetn, .hreadyout, .hresp, .mode_pins, .tx_data, .tx_ctrl,
  .tx_word, .tx_is_ctrl, .pattern_error_flag_n, .word_sync_out,
  .idle_insert, .idle_delete, .recenter, .word_clk_ratio, .half_rate,
  .coding_bypass
);

// ===== tb/qsmc_host_model.sv
// Host model: drives the static mode pins and the word sync input.
// Assumes requests come from the bench on hclk; one clock is locked.
`timescale 1ns/1ps
module qsmc_host_model (
  input  wire logic                 hclk,
  input  wire qsmc_pkg::qsmc_mode_s want,
  input  wire logic                 sync_req,
  output qsmc_pkg::qsmc_mode_s      pins,
  output logic                      ws_in
);
  import qsmc_pkg::*;
  logic [2:0] hold_q;
  initial begin
    pins = 7'h66;
    ws_in = 1'b0;
    hold_q = 3'h0;
  end
  // Pins follow want; buffer_recenter_n is held low for four cycles after each change
  always @(posedge hclk) begin
    ws_in <= sync_req;
    if (want[4:0] !== pins[4:0]) begin
      pins <= {2'b10, want[4:0]};
      hold_q <= 3'h4;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
      pins[5] <= (hold_q == 3'h1);
    end
  end
endmodule : qsmc_host_model

// ===== tb/qsmc_top_tb.sv
// Testbench: self-checking scenarios for the mode control top.
// Assumes the host model drives mode pins and word sync input.
`timescale 1ns/1ps
module qsmc_top_tb;
  import qsmc_pkg::*;
  localparam int          NCH  = 4;
  localparam logic [39:0] TDAT = 40'hc3_a5f0_1e69;
  logic               hclk = 1'b0;
  logic               hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0]        haddr, hwdata, hrdata, q;
  logic [1:0]         htrans;
  qsmc_mode_s         want, mode_pins;
  logic               sync_req, word_sync_in, word_sync_out;
  logic [NCH*10-1:0]  tx_data, tx_word, rx_data;
  logic [NCH-1:0]     tx_ctrl, tx_is_ctrl, rx_valid, pattern_error_flag_n;
  logic               idle_insert, idle_delete, recenter;
  logic               half_rate, coding_bypass;
  logic [4:0]         word_clk_ratio;
  logic               tck, tms, tdi, trst_n, tdo;
  int                 mismatches = 0;
  int                 n_compared = 0;

  always #5 hclk = ~hclk;

  qsmc_top #(.NCH(NCH)) i_qsmc_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq,
    .mode_pins, .tx_data, .tx_ctrl, .tx_word, .tx_is_ctrl, .rx_data,
    .rx_valid, .pattern_error_flag_n, .word_sync_in, .word_sync_out,
    .idle_insert, .idle_delete, .recenter, .word_clk_ratio, .half_rate,
    .coding_bypass, .tck, .tms, .tdi, .trst_n, .tdo
  );
  qsmc_host_model i_qsmc_host_model (
    .hclk, .want, .sync_req, .pins(mode_pins), .ws_in(word_sync_in)
  );

  task automatic give_verdict;
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [39:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      give_verdict;
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [31:0] a, d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask : bus

  task automatic count_to(input int w, input int lim, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (!(w ? (idle_insert | idle_delete) : word_sync_out)
               && n < lim);
  endtask : count_to

  // One slow test clock period, well below a quarter of hclk
  task automatic jtag_step(input logic m, input logic di);
    tms <= m;
    tdi <= di;
    repeat (2) @(posedge hclk);
    tck <= 1'b1;
    repeat (2) @(posedge hclk);
    tck <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : jtag_step

  task automatic t_jtag;
    trst_n <= 1'b0;
    repeat (2) @(posedge hclk);
    trst_n <= 1'b1;
    jtag_step(1'b0, 1'b0);
    jtag_step(1'b1, 1'b0);
    jtag_step(1'b0, 1'b0);
    jtag_step(1'b0, 1'b0);
    jtag_step(1'b0, 1'b1);
    check("tdo_capture", tdo, 1'b0);
    jtag_step(1'b0, 1'b0);
    check("tdo_shift_one", tdo, 1'b1);
    jtag_step(1'b0, 1'b1);
    check("tdo_shift_zero", tdo, 1'b0);
  endtask : t_jtag

  task automatic t_regs;
    bus(1'b0, QSMC_OFF_CTRL, 32'h0, q);
    check("ctrl_reset", q[7:0], QSMC_PER_RST);
    bus(1'b0, QSMC_OFF_IMASK, 32'h0, q);
    check("imask_reset", q, QSMC_IMASK_RST);
    bus(1'b0, QSMC_OFF_MODE, 32'h0, q);
    check("mode_pins", q[6:0], 7'h66);
    bus(1'b1, 32'h020, 32'hffff_ffff, q);
    bus(1'b0, 32'h020, 32'h0, q);
    check("unmapped", q, 32'h0);
    bus(1'b1, QSMC_OFF_CTRL, 32'h5, q);
    bus(1'b0, QSMC_OFF_CTRL, 32'h0, q);
    check("ctrl_write", q[7:0], 8'h05);
  endtask : t_regs

  task automatic t_modes;
    logic [4:0]  tbl [4];
    logic [39:0] e;
    logic [4:0]  r;
    tbl = '{5'h01, 5'h04, 5'h03, 5'h06};
    for (int i = 0; i < 4; i++) begin
      want <= {2'b11, tbl[i]};
      tx_data <= TDAT;
      tx_ctrl <= 4'ha;
      repeat (3) @(posedge hclk);
      check("recenter", recenter, 1'b1);
      repeat (8) @(posedge hclk);
      r = tbl[i][0] ? QSMC_RATIO_DUAL : QSMC_RATIO_SINGLE;
      check("ratio", word_clk_ratio, r);
      check("half_rate", half_rate, !tbl[i][1]);
      check("bypass", coding_bypass, !tbl[i][2]);
      for (int c = 0; c < NCH; c++)
        e[c*10+:10] = tbl[i][2] ? {2'b00, TDAT[c*10+:8]} : TDAT[c*10+:10];
      check("tx_word", tx_word, e);
      check("tx_ctrl", tx_is_ctrl, tbl[i][2] ? 4'ha : 4'h0);
    end
  endtask : t_modes

  task automatic t_self_test_enable;
    logic [7:0]  s;
    logic [39:0] w;
    want <= {2'b11, 5'h16};
    repeat (10) @(posedge hclk);
    bus(1'b1, QSMC_OFF_IMASK, 32'h2, q);
    bus(1'b0, QSMC_OFF_ISTAT, 32'h0, q);
    check("irq_masked", irq, 1'b0);
    s = tx_word[7:0];
    for (int k = 1; k < 300; k++) begin
      w = {NCH{2'b00, 8'(k)}};
      if (k == 200) w[17:10] = 8'h00;
      rx_valid <= '1;
      rx_data <= w;
      @(posedge hclk);
      check("pattern", tx_word, {NCH{2'b00, 8'(s + k)}});
      if (k > 5 && k < 200) check("flag", pattern_error_flag_n, 4'h0);
    end
    rx_valid <= '0;
    repeat (3) @(posedge hclk);
    check("irq_set", irq, 1'b1);
    bus(1'b0, QSMC_OFF_ISTAT, 32'h0, q);
    check("istat_err", q[5:0], 6'h02);
    repeat (2) @(posedge hclk);
    check("irq_clear", irq, 1'b0);
    want <= {2'b11, 5'h06};
    repeat (10) @(posedge hclk);
    check("flag_off", pattern_error_flag_n, 4'hf);
  endtask : t_self_test_enable

  task automatic t_sync;
    int n;
    count_to(0, 50, n);
    count_to(0, 50, n);
    check("sync_gap", n, 6);
    sync_req <= 1'b1;
    count_to(1, 8, n);
    check("idle_unlocked", n < 8, 1'b1);
    bus(1'b0, QSMC_OFF_ISTAT, 32'h0, q);
    check("istat_sync", q[NCH], 1'b1);
    sync_req <= 1'b0;
    want <= {2'b11, 5'h0e};
    repeat (10) @(posedge hclk);
    sync_req <= 1'b1;
    count_to(1, 8, n);
    check("idle_locked", n, 8);
    sync_req <= 1'b0;
  endtask : t_sync

  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    give_verdict;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    want = 7'h66;
    sync_req = 1'b0;
    tx_data = '0;
    tx_ctrl = '0;
    rx_data = '0;
    rx_valid = '0;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_modes;
    t_self_test_enable;
    t_sync;
    t_jtag;
    give_verdict;
  end
endmodule : qsmc_top_tb
